// ### src/hsd_device.sv
// Display slave end: bus receiver/transmitter and control-byte command decoder
//
// Operation
// - Master enters Hs-mode: START, master code, not-acknowledge
// - Slave never acknowledges the master code
// - Master then sends Sr, address, samples acknowledge
// - Hs-mode kept until STOP only
// - Acknowledge own address, ignore other transfers
// - Write carries control byte plus data byte pairs
// - Acknowledge every control and data byte
// - Control byte MSB is the continuation flag
// - Flag one: one data byte, then control
// - Flag zero: data bytes until STOP or Sr
// - Stream bytes follow last control byte's select
// - Bit six selects display data or command
// - Select zero: byte goes to command decoder
// - Select one: RAM write, pointer auto-advances
// - Read with select zero returns status byte
// - Read with select one returns no RAM
// - Read drives data after ack until NACK
// - Select set by write ending in Sr
// - Master chains transfers by Sr, STOP ends
`timescale 1ns/1ps
`default_nettype none
module hsd_device #(
    parameter logic [6:0] OWN_ADDR = hsd_pkg::HSD_OWN_ADDR_DEFAULT,
    parameter int PTR_WIDTH = hsd_pkg::HSD_PTR_WIDTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic link_clk,
    hsd_if.dev bus,
    input wire logic [7:0] status_byte,
    input wire logic ptr_load,
    input wire logic [PTR_WIDTH-1:0] ptr_value,
    output logic cmd_valid,
    output logic [7:0] cmd_byte,
    output logic ram_wr,
    output logic [PTR_WIDTH-1:0] ram_addr,
    output logic [7:0] ram_data,
    output logic hs_active
);
    import hsd_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_ADDR_ACK = 3'h2,
        ST_WR = 3'h3,
        ST_WR_ACK = 3'h4,
        ST_RD = 3'h5,
        ST_RD_ACK = 3'h6
    } hsd_state_type;

    // ---- Link domain, clocked by link_clk ----
    logic [1:0] pins_s;
    logic [7:0] status_l;
    logic scl_d, sda_d;
    hsd_state_type state, next_state;
    logic [2:0] bit_cnt, next_bit_cnt;
    logic [7:0] shift, next_shift;
    logic is_read, next_is_read;
    logic expect_ctrl, next_expect_ctrl;
    logic continuation_flag, next_continuation_flag;
    logic sel, next_sel;
    logic hs_mode, next_hs_mode;
    logic sda_low, next_sda_low;
    logic half, next_half;
    logic evt_tog, next_evt_tog;
    logic [7:0] evt_byte, next_evt_byte;
    logic evt_ram, next_evt_ram;
    logic scl_rise, scl_fall, start_c, stop_c;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;

    // Pins come from another domain and are synchronised first
    hsd_sync #(.WIDTH(2)) u_pin_sync (
        .clk(link_clk),
        .rst(rst),
        .d({bus.scl, bus.sda}),
        .q(pins_s)
    );

    // Status is quasi-static; a byte read mid-update may mix old and new bits
    hsd_sync #(.WIDTH(8)) u_status_sync (
        .clk(link_clk),
        .rst(rst),
        .d(status_byte),
        .q(status_l)
    );

    // Bus events seen on the synchronised lines
    assign scl_rise = pins_s[1] & !scl_d;
    assign scl_fall = !pins_s[1] & scl_d;
    assign start_c = pins_s[1] & scl_d & sda_d & !pins_s[0];
    assign stop_c = pins_s[1] & scl_d & !sda_d & pins_s[0];
    assign rx_byte = {shift[6:0], pins_s[0]};
    assign tx_byte = sel ? HSD_NO_READBACK : status_l;

    // Open-drain data: only ever pulls low
    assign bus.sda_out_d = 1'b0;
    assign bus.sda_oe_d = sda_low;

    // Next-state logic of the bus engine and decoder
    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shift = shift;
        next_is_read = is_read;
        next_expect_ctrl = expect_ctrl;
        next_continuation_flag = continuation_flag;
        next_sel = sel;
        next_hs_mode = hs_mode;
        next_sda_low = sda_low;
        next_half = half;
        next_evt_tog = evt_tog;
        next_evt_byte = evt_byte;
        next_evt_ram = evt_ram;
        if (stop_c) begin
            // Only a STOP leaves Hs-mode
            next_state = ST_IDLE;
            next_hs_mode = 1'b0;
            next_sda_low = 1'b0;
            next_expect_ctrl = 1'b1;
        end else if (start_c) begin
            // START or Sr: mode kept, decoder back to control byte
            next_state = ST_ADDR;
            next_bit_cnt = '0;
            next_sda_low = 1'b0;
            next_expect_ctrl = 1'b1;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    // Unaddressed or finished: wait for the next START
                end
                ST_ADDR, ST_WR: begin
                    if (scl_rise) begin
                        next_shift = rx_byte;
                        next_bit_cnt = bit_cnt + 3'h1;
                        if (bit_cnt == HSD_LAST_BIT) begin
                            next_half = 1'b0;
                            if (state == ST_ADDR) begin
                                if ((rx_byte & HSD_MCODE_MASK) == HSD_MCODE_VALUE) begin
                                    // Master code is never acknowledged
                                    next_hs_mode = 1'b1;
                                    next_state = ST_IDLE;
                                end else if (rx_byte[7:1] == OWN_ADDR) begin
                                    next_is_read = rx_byte[HSD_RW_BIT];
                                    next_state = ST_ADDR_ACK;
                                end else begin
                                    next_state = ST_IDLE;
                                end
                            end else begin
                                next_state = ST_WR_ACK;
                                if (expect_ctrl) begin
                                    next_continuation_flag = rx_byte[HSD_CONT_BIT];
                                    next_sel = rx_byte[HSD_SEL_BIT];
                                    next_expect_ctrl = 1'b0;
                                end else begin
                                    // Data byte routed by the latest select
                                    next_evt_tog = !evt_tog;
                                    next_evt_byte = rx_byte;
                                    next_evt_ram = sel;
                                    next_expect_ctrl = continuation_flag;
                                end
                            end
                        end
                    end
                end
                ST_ADDR_ACK, ST_WR_ACK: begin
                    if (scl_fall) begin
                        if (!half) begin
                            next_sda_low = 1'b1;
                            next_half = 1'b1;
                        end else begin
                            next_half = 1'b0;
                            next_bit_cnt = '0;
                            if (state == ST_ADDR_ACK && is_read) begin
                                // First data bit goes out on the ack's closing edge
                                next_sda_low = !tx_byte[7];
                                next_shift = {tx_byte[6:0], 1'b0};
                                next_state = ST_RD;
                            end else begin
                                next_sda_low = 1'b0;
                                next_state = ST_WR;
                            end
                        end
                    end
                end
                ST_RD: begin
                    if (scl_rise) begin
                        next_bit_cnt = bit_cnt + 3'h1;
                        if (bit_cnt == HSD_LAST_BIT) begin
                            next_state = ST_RD_ACK;
                            next_half = 1'b0;
                        end
                    end else if (scl_fall) begin
                        next_sda_low = !shift[7];
                        next_shift = {shift[6:0], 1'b0};
                    end
                end
                ST_RD_ACK: begin
                    if (scl_fall && !half) begin
                        next_sda_low = 1'b0;
                    end else if (scl_rise) begin
                        if (pins_s[0]) begin
                            next_state = ST_IDLE;
                        end else begin
                            next_half = 1'b1;
                        end
                    end else if (scl_fall && half) begin
                        // Master acknowledged: send another byte
                        next_sda_low = !tx_byte[7];
                        next_shift = {tx_byte[6:0], 1'b0};
                        next_bit_cnt = '0;
                        next_state = ST_RD;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    // Link-domain registers
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            state <= ST_IDLE;
            bit_cnt <= '0;
            shift <= '0;
            is_read <= 1'b0;
            expect_ctrl <= 1'b1;
            continuation_flag <= 1'b0;
            sel <= 1'b0;
            hs_mode <= 1'b0;
            sda_low <= 1'b0;
            half <= 1'b0;
            evt_tog <= 1'b0;
            evt_byte <= '0;
            evt_ram <= 1'b0;
        end else begin
            scl_d <= pins_s[1];
            sda_d <= pins_s[0];
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
            is_read <= next_is_read;
            expect_ctrl <= next_expect_ctrl;
            continuation_flag <= next_continuation_flag;
            sel <= next_sel;
            hs_mode <= next_hs_mode;
            sda_low <= next_sda_low;
            half <= next_half;
            evt_tog <= next_evt_tog;
            evt_byte <= next_evt_byte;
            evt_ram <= next_evt_ram;
        end
    end

    // ---- User domain, clocked by clk ----
    logic [1:0] evt_s;
    logic evt_seen, next_evt_seen;
    logic next_cmd_valid, next_ram_wr;
    logic [7:0] next_cmd_byte, next_ram_data;
    logic [PTR_WIDTH-1:0] ptr, next_ptr, next_ram_addr;
    logic evt_new;

    // Event toggle and mode level cross by two flip-flops
    hsd_sync #(.WIDTH(2)) u_evt_sync (
        .clk(clk),
        .rst(rst),
        .d({evt_tog, hs_mode}),
        .q(evt_s)
    );

    // Byte and route stay still for a whole byte time after the toggle
    assign evt_new = evt_s[1] ^ evt_seen;

    // Deliver each received data byte to RAM or the command decoder
    always_comb begin
        next_evt_seen = evt_s[1];
        next_cmd_valid = 1'b0;
        next_cmd_byte = cmd_byte;
        next_ram_wr = 1'b0;
        next_ram_addr = ram_addr;
        next_ram_data = ram_data;
        next_ptr = ptr;
        if (evt_new) begin
            if (evt_ram) begin
                next_ram_wr = 1'b1;
                next_ram_addr = ptr;
                next_ram_data = evt_byte;
                next_ptr = ptr + 1'b1;
            end else begin
                next_cmd_valid = 1'b1;
                next_cmd_byte = evt_byte;
            end
        end
        // A pointer load from the command side overrides the increment
        if (ptr_load) begin
            next_ptr = ptr_value;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            evt_seen <= 1'b0;
            cmd_valid <= 1'b0;
            cmd_byte <= '0;
            ram_wr <= 1'b0;
            ram_addr <= '0;
            ram_data <= '0;
            ptr <= PTR_WIDTH'(HSD_PTR_RESET);
            hs_active <= 1'b0;
        end else begin
            evt_seen <= next_evt_seen;
            cmd_valid <= next_cmd_valid;
            cmd_byte <= next_cmd_byte;
            ram_wr <= next_ram_wr;
            ram_addr <= next_ram_addr;
            ram_data <= next_ram_data;
            ptr <= next_ptr;
            hs_active <= evt_s[0];
        end
    end
endmodule
`default_nettype wire

// ### src/hsd_pkg.sv
// Shared constants and types for the high-speed two-wire command link
package hsd_pkg;
    // Master code pattern 0000 1xxx: upper five bits compared
    localparam logic [7:0] HSD_MCODE_MASK = 8'hF8;
    localparam logic [7:0] HSD_MCODE_VALUE = 8'h08;
    // Control byte fields and address byte direction bit
    localparam int HSD_CONT_BIT = 7;
    localparam int HSD_SEL_BIT = 6;
    localparam int HSD_RW_BIT = 0;
    // Own bus address default, arbitrary value
    localparam logic [6:0] HSD_OWN_ADDR_DEFAULT = 7'h3C;
    // Byte sent when display memory read back is asked for
    localparam logic [7:0] HSD_NO_READBACK = 8'hFF;
    localparam logic [2:0] HSD_LAST_BIT = 3'h7;
    localparam logic [3:0] HSD_ACK_SLOT = 4'h8;
    // Display data pointer
    localparam int HSD_PTR_WIDTH = 11;
    localparam int HSD_PTR_RESET = 0;
    // Bus timing: 200 MHz system clock, Hs-mode bit time
    localparam int HSD_CLK_PERIOD_PS = 5000;
    localparam int HSD_BIT_TIME_NS = 300;
    localparam int HSD_QUARTER_CYC =
        (HSD_BIT_TIME_NS * 1000 + 4 * HSD_CLK_PERIOD_PS - 1) / (4 * HSD_CLK_PERIOD_PS);
    // Host bus operations
    typedef enum logic [2:0] {
        HSD_OP_START = 3'h0,
        HSD_OP_STOP = 3'h1,
        HSD_OP_WRITE = 3'h2,
        HSD_OP_READ = 3'h3,
        HSD_OP_MCODE = 3'h4
    } hsd_op_type;
endpackage

// ### src/hsd_if.sv
// Open-drain two-wire bus joining the bus master and the display slave
`timescale 1ns/1ps
`default_nettype none
interface hsd_if;
    logic scl_out_h;
    logic scl_oe_h;
    logic sda_out_h;
    logic sda_oe_h;
    logic sda_out_d;
    logic sda_oe_d;
    logic scl;
    logic sda;
    // Wired-AND with pull-up: a line is low only where a driver enables low
    assign scl = !scl_oe_h | scl_out_h;
    assign sda = (!sda_oe_h | sda_out_h) & (!sda_oe_d | sda_out_d);
    modport host(output scl_out_h, output scl_oe_h, output sda_out_h, output sda_oe_h,
                 input scl, input sda);
    modport dev(output sda_out_d, output sda_oe_d, input scl, input sda);
endinterface
`default_nettype wire

// ### src/hsd_sync.sv
// Two flip-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ps
`default_nettype none
module hsd_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_q;

    // First stage feeds only the second stage
    always_comb begin
        next_stage1 = d;
        next_q = stage1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1 <= '0;
            q <= '0;
        end else begin
            stage1 <= next_stage1;
            q <= next_q;
        end
    end
endmodule
`default_nettype wire

// ### src/hsd_host.sv
// Bus master end: executes START, STOP, byte write and byte read operations
`timescale 1ns/1ps
`default_nettype none
module hsd_host #(
    parameter int QUARTER = hsd_pkg::HSD_QUARTER_CYC
) (
    input wire logic clk,
    input wire logic rst,
    hsd_if.host bus,
    input wire logic op_valid,
    output logic op_ready,
    input wire hsd_pkg::hsd_op_type op,
    input wire logic [7:0] op_data,
    input wire logic op_ack,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_acked
);
    import hsd_pkg::*;

    typedef enum logic [1:0] {
        H_IDLE = 2'h0,
        H_START = 2'h1,
        H_STOP = 2'h2,
        H_BYTE = 2'h3
    } hsd_hstate_type;

    hsd_hstate_type state, next_state;
    logic [15:0] q_cnt, next_q_cnt;
    logic [1:0] phase, next_phase;
    logic [3:0] bit_idx, next_bit_idx;
    logic scl_low, next_scl_low;
    logic sda_low, next_sda_low;
    logic [7:0] tx, next_tx;
    logic [7:0] rx, next_rx;
    logic is_read, next_is_read;
    logic ackbit, next_ackbit;
    logic next_rsp_valid, next_rsp_acked;
    logic [7:0] next_rsp_data;
    logic sda_s;
    logic tick;

    // Data line is shared with the slave, so it is synchronised
    hsd_sync #(.WIDTH(1)) u_sda_sync (
        .clk(clk),
        .rst(rst),
        .d(bus.sda),
        .q(sda_s)
    );

    assign bus.scl_out_h = 1'b0;
    assign bus.scl_oe_h = scl_low;
    assign bus.sda_out_h = 1'b0;
    assign bus.sda_oe_h = sda_low;
    assign op_ready = (state == H_IDLE);
    assign tick = (q_cnt == 16'(QUARTER - 1));

    // Quarter-bit sequencer: the clock is divided down from clk
    always_comb begin
        next_state = state;
        next_q_cnt = tick ? '0 : q_cnt + 16'h1;
        next_phase = phase;
        next_bit_idx = bit_idx;
        next_scl_low = scl_low;
        next_sda_low = sda_low;
        next_tx = tx;
        next_rx = rx;
        next_is_read = is_read;
        next_ackbit = ackbit;
        next_rsp_valid = 1'b0;
        next_rsp_data = rsp_data;
        next_rsp_acked = rsp_acked;
        if (state == H_IDLE) begin
            next_q_cnt = '0;
            next_phase = '0;
            next_bit_idx = '0;
            if (op_valid) begin
                unique case (op)
                    HSD_OP_START: next_state = H_START;
                    HSD_OP_STOP: next_state = H_STOP;
                    HSD_OP_MCODE: begin
                        next_state = H_BYTE;
                        next_tx = HSD_MCODE_VALUE;
                        next_is_read = 1'b0;
                    end
                    HSD_OP_WRITE: begin
                        next_state = H_BYTE;
                        next_tx = op_data;
                        next_is_read = 1'b0;
                    end
                    HSD_OP_READ: begin
                        next_state = H_BYTE;
                        next_tx = '0;
                        next_is_read = 1'b1;
                        next_ackbit = op_ack;
                    end
                    default: next_state = H_IDLE;
                endcase
            end
        end else if (tick) begin
            next_phase = phase + 2'h1;
            unique case (state)
                H_START: begin
                    // Release data while clock low, then fall data with clock high
                    unique case (phase)
                        2'h0: next_sda_low = 1'b0;
                        2'h1: next_scl_low = 1'b0;
                        2'h2: next_sda_low = 1'b1;
                        2'h3: begin
                            next_scl_low = 1'b1;
                            next_state = H_IDLE;
                        end
                    endcase
                end
                H_STOP: begin
                    unique case (phase)
                        2'h0: begin
                            next_scl_low = 1'b1;
                            next_sda_low = 1'b1;
                        end
                        2'h1: next_scl_low = 1'b0;
                        2'h2: next_sda_low = 1'b0;
                        2'h3: next_state = H_IDLE;
                    endcase
                end
                default: begin
                    unique case (phase)
                        2'h0: begin
                            if (bit_idx == HSD_ACK_SLOT) begin
                                next_sda_low = is_read & ackbit;
                            end else begin
                                next_sda_low = !is_read & !tx[7];
                            end
                        end
                        2'h1: next_scl_low = 1'b0;
                        2'h2: begin
                            // Sample in mid-high, well after the sync delay
                            if (bit_idx == HSD_ACK_SLOT) begin
                                next_rsp_acked = !sda_s;
                            end else begin
                                next_rx = {rx[6:0], sda_s};
                                next_tx = {tx[6:0], 1'b0};
                            end
                        end
                        2'h3: begin
                            next_scl_low = 1'b1;
                            if (bit_idx == HSD_ACK_SLOT) begin
                                next_rsp_valid = 1'b1;
                                next_rsp_data = rx;
                                next_state = H_IDLE;
                            end else begin
                                next_bit_idx = bit_idx + 4'h1;
                            end
                        end
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= H_IDLE;
            q_cnt <= '0;
            phase <= '0;
            bit_idx <= '0;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
            tx <= '0;
            rx <= '0;
            is_read <= 1'b0;
            ackbit <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= '0;
            rsp_acked <= 1'b0;
        end else begin
            state <= next_state;
            q_cnt <= next_q_cnt;
            phase <= next_phase;
            bit_idx <= next_bit_idx;
            scl_low <= next_scl_low;
            sda_low <= next_sda_low;
            tx <= next_tx;
            rx <= next_rx;
            is_read <= next_is_read;
            ackbit <= next_ackbit;
            rsp_valid <= next_rsp_valid;
            rsp_data <= next_rsp_data;
            rsp_acked <= next_rsp_acked;
        end
    end
endmodule
`default_nettype wire

// ### bench/hsd_properties.sv
// Checker of the open-drain link
`timescale 1ns/1ps
`default_nettype none
module hsd_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_out_h,
    input wire logic scl_oe_h,
    input wire logic sda_out_h,
    input wire logic sda_oe_h,
    input wire logic sda_out_d,
    input wire logic sda_oe_d,
    input wire logic scl,
    input wire logic sda
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Device takes SDA only while SCL is low, so it never fakes a START
    chk_dev_takes_low: assert property ($rose(sda_oe_d) |-> !scl)
        else $error("device took SDA while SCL high");
    // Open-drain: a driver may only pull low
    chk_host_pulls_low: assert property (scl_oe_h |-> !scl_out_h) else $error("bad");
    // Host moves SDA under a high SCL only for START or STOP
    chk_host_sda_framing: assert property (scl && $past(scl) && $changed(sda_oe_h)
        |-> scl[*3]) else $error("host moved SDA inside a data bit");
    // Slave data may change only while SCL is low
    chk_dev_sda_stable: assert property (scl && $past(scl) |-> $stable(sda_oe_d))
        else $error("bad");
    // An acknowledge or data bit ends within 40 clk cycles
    chk_ack_one_bit: assert property ($rose(sda_oe_d) |-> ##[1:40] !sda_oe_d)
        else $error("bad");
    chk_start_scl_hold: assert property (scl && $fell(sda) |-> scl[*3]) else $error("bad");
    chk_stop_released: assert property (scl && $rose(sda) |-> !sda_oe_h && !sda_oe_d)
        else $error("bad");
    chk_quiet_after_rst: assert property ($fell(rst) |-> !sda_oe_d && !scl_oe_h)
        else $error("bad");
endmodule
`default_nettype wire

// ### bench/i2c_hs_slave_command_decoder_tb.sv
// Bench joining host and display ends
`timescale 1ns/1ps
`default_nettype none
module i2c_hs_slave_command_decoder_tb;
    import hsd_pkg::*;
    logic clk = 0, rst = 1, link_clk = 0, op_valid = 0, op_ack = 0, ptr_load = 0;
    logic [7:0] op_data = 8'h00;
    hsd_op_type op = HSD_OP_START;
    logic op_ready, rsp_valid, rsp_acked, cmd_valid, ram_wr, hs_active;
    logic [7:0] rsp_data, cmd_byte, ram_data;
    logic [10:0] ram_addr;
    logic [19:0] evq[$];
    int mismatches = 0, n_tests = 0;
    hsd_if hsd_if_i ();
    hsd_device hsd_device_i (.clk(clk), .rst(rst), .link_clk(link_clk), .bus(hsd_if_i.dev),
        .status_byte(8'hAA), .ptr_load(ptr_load), .ptr_value(11'h7FF), .cmd_valid(cmd_valid),
        .cmd_byte(cmd_byte), .ram_wr(ram_wr), .ram_addr(ram_addr), .ram_data(ram_data),
        .hs_active(hs_active));
    // Quarter of 6 leaves the slave's sync delay room inside SCL low
    hsd_host #(.QUARTER(6)) hsd_host_i (.clk(clk), .rst(rst), .bus(hsd_if_i.host),
        .op_valid(op_valid), .op_ready(op_ready), .op(op), .op_data(op_data), .op_ack(op_ack),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_acked(rsp_acked));
    hsd_properties hsd_properties_i (.clk(clk), .rst(rst), .scl_out_h(hsd_if_i.scl_out_h),
        .scl_oe_h(hsd_if_i.scl_oe_h), .sda_out_h(hsd_if_i.sda_out_h),
        .sda_oe_h(hsd_if_i.sda_oe_h), .sda_out_d(hsd_if_i.sda_out_d),
        .sda_oe_d(hsd_if_i.sda_oe_d), .scl(hsd_if_i.scl), .sda(hsd_if_i.sda));
    // Clocks of unrelated phase
    initial forever #2.5 clk = ~clk;
    initial begin
        #3.7;
        forever #7.5 link_clk = ~link_clk;
    end
    // Log user events in arrival order
    always @(negedge clk) begin
        if (ram_wr === 1'b1) evq.push_back({1'b1, ram_addr, ram_data});
        if (cmd_valid === 1'b1) evq.push_back({12'h000, cmd_byte});
    end
    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // One host operation, held until taken, then waited out
    task automatic run(input hsd_op_type o, input logic [7:0] d, input logic a);
        int n;
        n = 0;
        @(negedge clk);
        op_valid = 1'b1;
        op = o;
        op_data = d;
        op_ack = a;
        while (op_ready !== 1'b1 && n < 500) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        op_valid = 1'b0;
        while (op_ready !== 1'b1 && n < 500) begin
            @(negedge clk);
            n++;
        end
        if (n >= 500) mismatches++;
    endtask
    task automatic wr(input logic [7:0] d, input logic k);
        run(HSD_OP_WRITE, d, 1'b0);
        check(20'(rsp_acked), 20'(k));
    endtask
    task automatic rd(input logic a, input logic [7:0] e);
        run(HSD_OP_READ, 8'h00, a);
        check(20'(rsp_data), 20'(e));
    endtask
    task automatic ev(input logic [19:0] e);
        logic [19:0] g;
        g = 20'hFFFFF;
        if (evq.size() > 0) g = evq.pop_front();
        check(g, e);
    endtask
    task automatic report_and_stop();
        $display("compares %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected run of some 5000 cycles
    initial begin
        #200000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        ptr_load = 1'b1;
        @(negedge clk);
        ptr_load = 1'b0;
        run(HSD_OP_START, 8'h00, 1'b0);
        run(HSD_OP_MCODE, 8'h00, 1'b0);
        check(20'(rsp_acked), 20'h0);
        run(HSD_OP_START, 8'h00, 1'b0);
        wr(8'h78, 1'b1);
        wr(8'hC0, 1'b1);
        wr(8'h11, 1'b1);
        ev(20'hFFF11);
        wr(8'h80, 1'b1);
        wr(8'h22, 1'b1);
        ev(20'h00022);
        wr(8'h40, 1'b1);
        wr(8'h33, 1'b1);
        wr(8'hC4, 1'b1);
        ev(20'h80033);
        ev(20'h801C4);
        run(HSD_OP_START, 8'h00, 1'b0);
        check(20'(hs_active), 20'h1);
        wr(8'h78, 1'b1);
        wr(8'h00, 1'b1);
        wr(8'h55, 1'b1);
        ev(20'h00055);
        run(HSD_OP_START, 8'h00, 1'b0);
        wr(8'h79, 1'b1);
        rd(1'b1, 8'hAA);
        rd(1'b0, 8'hAA);
        run(HSD_OP_START, 8'h00, 1'b0);
        wr(8'h78, 1'b1);
        wr(8'h40, 1'b1);
        run(HSD_OP_START, 8'h00, 1'b0);
        wr(8'h79, 1'b1);
        rd(1'b0, 8'hFF);
        run(HSD_OP_START, 8'h00, 1'b0);
        wr(8'h7A, 1'b0);
        wr(8'hC0, 1'b0);
        run(HSD_OP_STOP, 8'h00, 1'b0);
        repeat (30) @(negedge clk);
        check(20'(hs_active), 20'h0);
        check(20'(evq.size()), 20'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
